// >>> pin_partner.sv
// pin side: pads loop back, else an outside driver, else pulls
// assumes the bench sets the outside driver
module pin_partner
   import port_group_pkg::*;
(
   input  wire logic       core_clk, // clock
   input  wire pad_ctrl_t  padCtrl,  // pad control
   input  wire logic [7:0] extEn,    // outside drive on
   input  wire logic [7:0] extLevel, // outside level
   output logic [7:0]      pinIn     // pin levels
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lastLevel_r;
   // remember the last level while something holds the pin
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 8; i++) begin
         if (padCtrl.outEnable[i] || extEn[i] || padCtrl.pullEnable[i]) begin
            lastLevel_r[i] <= pinIn[i];
         end
      end
   end
   // a pin nobody drives or pulls shows the inverse of its last level, so stale reads show
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pinIn[i] = padCtrl.outEnable[i] ? padCtrl.outValue[i] : extEn[i] ? extLevel[i]
            : padCtrl.pullEnable[i] ? padCtrl.pullDirection[i] : ~lastLevel_r[i];
      end
   end
endmodule : pin_partner

// >>> port_group0.sv
// port group 0: gpio, edge interrupts, pin function routing and the group summary register
// assumes pins already pass through pad cells; apb runs on core_clk
// assumes the chattering filter sits in the pad logic and takes only its enables from here
// assumes the interrupt controller samples pinIrqRequest and irq as levels

// Summary of operation
// - summary bits 12..0 read one while a group has a pending pin interrupt.
// - summary bit drops by itself once the last set pin flag of the group is cleared.
// - only interrupt-capable groups have summary bits; others read zero.
// - summary register is read-only, resets to zero, top bits read zero.
// - eight pins offer gpio and per-pin interrupt generation.
// - pin flag clears only on writing one; writing zero keeps it.
// - mode bit zero gives gpio; one routes pin by 2-bit function code.
// - all control fields reset to zero.
module port_group0
   import port_group_pkg::*;
(
   input  wire logic              core_clk,        // 40 MHz system clock
   input  wire logic              rst_n,           // synchronous reset, active low
   input  wire logic              psel,            // apb select
   input  wire logic              penable,         // apb access phase
   input  wire logic              pwrite,          // apb direction
   input  wire logic [7:0]        paddr,           // apb byte address
   input  wire logic [31:0]       pwdata,          // apb write data
   input  wire logic [3:0]        pstrb,           // apb byte strobes
   output logic                   pready,          // apb ready
   output logic [31:0]            prdata,          // apb read data
   output logic                   pslverr,         // apb error, unmapped address
   input  wire logic [7:0]        pinIn,           // pad input levels
   output pad_ctrl_t              padCtrl,         // pad drive and pull control
   output logic [7:0]             debounceEnable,  // filter enables toward pad logic
   input  wire periph_drive_t     dedicatedDrive,  // function 0 peripheral signals
   input  wire periph_drive_t     universalDrive,  // function 1 multiplexer signals
   output logic [7:0]             dedicatedIn,     // pin levels for function 0
   output logic [7:0]             universalIn,     // pin levels for function 1
   output logic [7:0]             pinIrqRequest,   // per pin requests to the controller
   output logic                   irq              // masked level interrupt
);

   // control registers
   // funcCode_r holds two bits per pin, pin 0 in the lowest pair
   logic [7:0]  outValue_r;
   logic [7:0]  outEnable_r;
   logic [7:0]  inEnable_r;
   logic [7:0]  pullEnable_r;
   logic [7:0]  pullDirection_r;
   logic [7:0]  irqFlag_r;
   logic [7:0]  irqEnable_r;
   logic [7:0]  edgeSelect_r;
   logic [7:0]  debounce_r;
   logic [7:0]  modeSelect_r;
   logic [15:0] funcCode_r;
   logic [7:0]  irqMask_r;

   // input synchroniser, three stages
   logic [7:0]  syncA_r;
   logic [7:0]  syncB_r;
   logic [7:0]  syncC_r;
   logic [7:0]  pinLevel_r;

   // bus decode terms
   logic        wrEn;
   logic        addrHit;

   // per-register write strobes, access phase only
   logic        wrData;
   logic        wrIoen;
   logic        wrPull;
   logic        wrFlags;
   logic        wrIrqCtl;
   logic        wrDebounce;
   logic        wrMode;
   logic        wrFunc;
   logic        wrMask;

   // edge and flag terms
   logic [7:0]  riseEv;
   logic [7:0]  fallEv;
   logic [7:0]  edgeEv;
   logic [7:0]  flagSet;
   logic [7:0]  flagClr;

   // summary and read path
   logic [12:0] groupPending;
   logic [15:0] pwLow;
   logic [31:0] readWord;

   // single-cycle answer: no wait states needed for plain registers
   assign pready  = 1'b1;
   assign wrEn    = psel & penable & pwrite;
   assign pslverr = psel & penable & ~addrHit;
   // an unstrobed byte writes as zero, so it can never clear a flag
   assign pwLow   = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};

   // one strobe per register keeps each register process small
   assign wrData     = wrEn && (paddr == OFS_DATA);
   assign wrIoen     = wrEn && (paddr == OFS_IOEN);
   assign wrPull     = wrEn && (paddr == OFS_PULL);
   assign wrFlags    = wrEn && (paddr == OFS_FLAGS);
   assign wrIrqCtl   = wrEn && (paddr == OFS_IRQCTL);
   assign wrDebounce = wrEn && (paddr == OFS_DEBOUNCE);
   assign wrMode     = wrEn && (paddr == OFS_MODESEL);
   assign wrFunc     = wrEn && (paddr == OFS_FUNCSEL);
   assign wrMask     = wrEn && (paddr == OFS_IRQMASK);

   // address decode: aligned offsets only, everything else is unmapped
   always_comb begin
      case (paddr)
         OFS_SUMMARY:  addrHit = 1'b1;
         OFS_DATA:     addrHit = 1'b1;
         OFS_IOEN:     addrHit = 1'b1;
         OFS_PULL:     addrHit = 1'b1;
         OFS_FLAGS:    addrHit = 1'b1;
         OFS_IRQCTL:   addrHit = 1'b1;
         OFS_DEBOUNCE: addrHit = 1'b1;
         OFS_MODESEL:  addrHit = 1'b1;
         OFS_FUNCSEL:  addrHit = 1'b1;
         OFS_IRQMASK:  addrHit = 1'b1;
         default:      addrHit = 1'b0;
      endcase
   end

   // three-stage chain; the first stage may go metastable, so only two and three are read
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         syncA_r <= RST_BYTE;
         syncB_r <= RST_BYTE;
         syncC_r <= RST_BYTE;
      end else begin
         syncA_r <= pinIn;
         syncB_r <= syncA_r;
         syncC_r <= syncB_r;
      end
   end

   // accepted level: a change counts once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pinLevel_r <= RST_BYTE;
      end else begin
         for (int i = 0; i < PIN_COUNT; i++) begin
            if (syncB_r[i] == syncC_r[i]) begin
               pinLevel_r[i] <= syncC_r[i];
            end
         end
      end
   end

   // edge detection per pin: stages two and three agree on the new level while the
   // accepted level still holds the old one; gated by input enable so a disabled
   // input is quiet and cannot raise a flag
   generate
      for (genvar g = 0; g < PIN_COUNT; g++) begin : gEdge
         assign riseEv[g] = inEnable_r[g] & syncB_r[g] & syncC_r[g] & ~pinLevel_r[g];
         assign fallEv[g] = inEnable_r[g] & ~syncB_r[g] & ~syncC_r[g] & pinLevel_r[g];
         assign edgeEv[g] = edgeSelect_r[g] ? fallEv[g] : riseEv[g];
      end
   endgenerate

   // flag set and write-one clear; set wins the tie, so an edge landing on
   // the clearing cycle is never lost
   assign flagSet = edgeEv;
   assign flagClr = wrFlags ? pwLow[7:0] : 8'h00;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irqFlag_r <= RST_BYTE;
      end else begin
         irqFlag_r <= (irqFlag_r & ~flagClr) | flagSet;
      end
   end

   // output data; the low byte is the input view and ignores writes
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         outValue_r <= RST_BYTE;
      end else if (wrData && pstrb[1]) begin
         outValue_r <= pwdata[15:8];
      end
   end

   // pad enables: input enable in the high byte, output enable in the low byte
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         inEnable_r  <= RST_BYTE;
         outEnable_r <= RST_BYTE;
      end else if (wrIoen) begin
         if (pstrb[1]) inEnable_r  <= pwdata[15:8];
         if (pstrb[0]) outEnable_r <= pwdata[7:0];
      end
   end

   // pull control: direction in the high byte, enable in the low byte
   // pulls apply whatever the routing, so a parked pin still sits at a known level
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pullDirection_r <= RST_BYTE;
         pullEnable_r    <= RST_BYTE;
      end else if (wrPull) begin
         if (pstrb[1]) pullDirection_r <= pwdata[15:8];
         if (pstrb[0]) pullEnable_r    <= pwdata[7:0];
      end
   end

   // interrupt control: edge select high byte, enable low byte
   // changing the edge select on a steady pin makes no event
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         edgeSelect_r <= RST_BYTE;
         irqEnable_r  <= RST_BYTE;
      end else if (wrIrqCtl) begin
         if (pstrb[1]) edgeSelect_r <= pwdata[15:8];
         if (pstrb[0]) irqEnable_r  <= pwdata[7:0];
      end
   end

   // filter enables, only passed on to the pad logic
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         debounce_r <= RST_BYTE;
      end else if (wrDebounce && pstrb[0]) begin
         debounce_r <= pwdata[7:0];
      end
   end

   // mode select, one bit per pin
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         modeSelect_r <= RST_BYTE;
      end else if (wrMode && pstrb[0]) begin
         modeSelect_r <= pwdata[7:0];
      end
   end

   // function codes, two bits per pin; only used while the mode bit is set
   // a half-written code can glitch routing for a cycle, so write both bytes at once
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         funcCode_r <= RST_HALF;
      end else if (wrFunc) begin
         if (pstrb[1]) funcCode_r[15:8] <= pwdata[15:8];
         if (pstrb[0]) funcCode_r[7:0]  <= pwdata[7:0];
      end
   end

   // interrupt mask for the single line, one means pass
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irqMask_r <= RST_BYTE;
      end else if (wrMask && pstrb[0]) begin
         irqMask_r <= pwdata[7:0];
      end
   end

   // summary: one bit per group; only interrupt-capable groups carry a value
   generate
      for (genvar k = 0; k < GROUP_COUNT; k++) begin : gSummary
         if (GROUP_IRQ_CAPABLE[k] && k == GROUP_SELF) begin : gOwn
            assign groupPending[k] = |irqFlag_r;
         end else begin : gAbsent
            assign groupPending[k] = 1'b0;
         end
      end
   endgenerate

   // read word of the addressed register; reserved bits and unmapped words read zero
   always_comb begin
      case (paddr)
         OFS_SUMMARY:  readWord = {19'h0_0000, groupPending};
         OFS_DATA:     readWord = {16'h0000, outValue_r, pinLevel_r & inEnable_r};
         OFS_IOEN:     readWord = {16'h0000, inEnable_r, outEnable_r};
         OFS_PULL:     readWord = {16'h0000, pullDirection_r, pullEnable_r};
         OFS_FLAGS:    readWord = {24'h00_0000, irqFlag_r};
         OFS_IRQCTL:   readWord = {16'h0000, edgeSelect_r, irqEnable_r};
         OFS_DEBOUNCE: readWord = {24'h00_0000, debounce_r};
         OFS_MODESEL:  readWord = {24'h00_0000, modeSelect_r};
         OFS_FUNCSEL:  readWord = {16'h0000, funcCode_r};
         OFS_IRQMASK:  readWord = {24'h00_0000, irqMask_r};
         default:      readWord = RST_WORD;
      endcase
   end

   // registered at the setup cycle, so the word stands through the access phase
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prdata <= RST_WORD;
      end else if (psel && !penable && !pwrite) begin
         prdata <= readWord;
      end
   end

   // pin routing: mode bit low gives gpio, high hands the pad to function 0 or 1;
   // codes 2 and 3 park the pin undriven with its input off, so no stray level
   // reaches either peripheral
   // pull control stays with the registers whatever the routing
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         dedicatedIn[i] = 1'b0;
         universalIn[i] = 1'b0;
         if (!modeSelect_r[i]) begin
            padCtrl.outValue[i]  = outValue_r[i];
            padCtrl.outEnable[i] = outEnable_r[i];
            padCtrl.inEnable[i]  = inEnable_r[i];
         end else begin
            case (funcCode_r[2*i +: 2])
               FN_DEDICATED: begin
                  padCtrl.outValue[i]  = dedicatedDrive.outValue[i];
                  padCtrl.outEnable[i] = dedicatedDrive.outEnable[i];
                  padCtrl.inEnable[i]  = 1'b1;
                  dedicatedIn[i]       = pinLevel_r[i];
               end
               FN_UNIVERSAL: begin
                  padCtrl.outValue[i]  = universalDrive.outValue[i];
                  padCtrl.outEnable[i] = universalDrive.outEnable[i];
                  padCtrl.inEnable[i]  = 1'b1;
                  universalIn[i]       = pinLevel_r[i];
               end
               default: begin
                  padCtrl.outValue[i]  = 1'b0;
                  padCtrl.outEnable[i] = 1'b0;
                  padCtrl.inEnable[i]  = 1'b0;
               end
            endcase
         end
         padCtrl.pullEnable[i]    = pullEnable_r[i];
         padCtrl.pullDirection[i] = pullDirection_r[i];
      end
   end

   // filter enables only; the filter and its slow clock live in the pad logic
   assign debounceEnable = debounce_r;

   // requests forwarded only for enabled pins; mask gates the single line
   // the flag itself stays set whatever the enable, so software can still poll it
   assign pinIrqRequest = irqFlag_r & irqEnable_r;
   assign irq           = |(pinIrqRequest & irqMask_r);

   // limitation: key-entry reset and the other port groups are outside this block

endmodule : port_group0

// >>> port_group0_checker.sv
// port-level assertions for port group 0
// assumes bind onto port_group0, one clock, zero-wait apb
module port_group0_checker
   import port_group_pkg::*;
(
   input wire logic        core_clk,      // clock
   input wire logic        rst_n,         // sync reset
   input wire logic        psel,          // select
   input wire logic        penable,       // access
   input wire logic        pwrite,        // write
   input wire logic [7:0]  paddr,         // address
   input wire logic [31:0] pwdata,        // write data
   input wire logic [31:0] prdata,        // read data
   input wire pad_ctrl_t   padCtrl,       // pads
   input wire logic [7:0]  dedicatedIn,   // function 0 in
   input wire logic [7:0]  universalIn,   // function 1 in
   input wire logic [7:0]  pinIrqRequest, // requests
   input wire logic        irq            // interrupt
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // access-phase decodes
   wire logic rdSum = psel && penable && !pwrite && paddr == OFS_SUMMARY;
   wire logic wrAcc = psel && penable && pwrite;
   // read data was loaded one edge back, so compare with the request seen then
   AST_SUM_OR: assert property (rdSum && (|$past(pinIrqRequest)) |-> prdata[0])
      else $error("summary low with a pin pending");
   AST_SUM_GAP: assert property (rdSum |-> prdata[12:1] == 12'h000) else $error("gap set");
   AST_SUM_TOP: assert property (rdSum |-> prdata[31:13] == 19'h0) else $error("top set");
   AST_IRQ_SRC: assert property (irq |-> |pinIrqRequest) else $error("irq, no request");
   AST_FN_EXCL: assert property ((dedicatedIn & universalIn) == 8'h00) else $error("2 routes");
   AST_RST: assert property ($rose(rst_n) |-> padCtrl == 40'h0 && !irq && !pinIrqRequest)
      else $error("not clear after reset");
   // a zero written to the flags, or any summary write, must not drop a request
   AST_W0_KEEP: assert property (wrAcc && paddr == OFS_FLAGS && pwdata[7:0] == 8'h00
      |=> ($past(pinIrqRequest) & ~pinIrqRequest) == 8'h00) else $error("zero cleared");
   AST_SUM_WR: assert property (wrAcc && paddr == OFS_SUMMARY
      |=> ($past(pinIrqRequest) & ~pinIrqRequest) == 8'h00) else $error("summary write acted");
endmodule : port_group0_checker

bind port_group0 port_group0_checker port_group0_checker_i (.core_clk, .rst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .padCtrl, .dedicatedIn, .universalIn, .pinIrqRequest, .irq);

// >>> port_group0_tb.sv
// bench for port group 0: apb master, pins through pin_partner
// assumes zero-wait apb and a four-edge input path
module port_group0_tb
   import port_group_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic          pready, pslverr, irq;
   logic [7:0]    paddr = 8'h00, extEn = 8'hFF, extLevel = 8'h80, pinIn, debounceEnable;
   logic [7:0]    dedicatedIn, universalIn, pinIrqRequest;
   logic [31:0]   pwdata = 32'h0, prdata;
   pad_ctrl_t     padCtrl;
   periph_drive_t dedicatedDrive = 16'hA5FF, universalDrive = 16'h5AFF;
   int            mismatches = 0, n_tests = 0, cyc = 0;
   port_group0 port_group0_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'h3), .pready, .prdata, .pslverr, .pinIn, .padCtrl, .debounceEnable,
      .dedicatedDrive, .universalDrive, .dedicatedIn, .universalIn, .pinIrqRequest, .irq);
   pin_partner pin_partner_i (.core_clk, .padCtrl, .extEn, .extLevel, .pinIn);
   // 25 ns clock
   initial forever #12.5 core_clk = ~core_clk;
   // hang guard, far above the roughly 130 cycles needed
   always @(posedge core_clk) if (++cyc == 3000) test_done();
   // compare and bus helpers; unmapped words must answer with an error
   task automatic chk(input logic [39:0] seen, input logic [39:0] expv);
      n_tests++;
      if (seen !== expv) mismatches++;
      if (seen !== expv) $display("[ERR] %0t seen %h want %h", $time, seen, expv);
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      if (!w) chk({pslverr, prdata}, {a > OFS_IRQMASK, d});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   task automatic test_done;
      if (cyc >= 3000) mismatches++;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   // all words read zero, the word past the map errors
   task automatic t_reset;
      for (int i = 0; i < 11; i++) apb(1'b0, 8'(4 * i), RST_WORD);
   endtask : t_reset
   // gpio loopback, then two pins per function code
   task automatic t_route;
      apb(1'b1, OFS_IOEN, 32'hFFFF);
      apb(1'b1, OFS_DATA, 32'hA5FF);
      apb(1'b1, OFS_DEBOUNCE, 32'h5A);
      apb(1'b0, OFS_DATA, 32'hA5A5);
      chk({padCtrl.outValue, padCtrl.outEnable, debounceEnable}, 24'hA5_FF5A);
      apb(1'b1, OFS_MODESEL, 32'hFF);
      apb(1'b1, OFS_FUNCSEL, 32'hE4E4);
      repeat (4) @(posedge core_clk);
      chk({padCtrl.outEnable, padCtrl.outValue & 8'h33}, 16'h3303);
      chk({dedicatedIn, universalIn}, 16'h0102);
      apb(1'b1, OFS_MODESEL, RST_WORD);
      apb(1'b1, OFS_IOEN, 32'hFF00);
   endtask : t_route
   // pin 7 falls, others rise; then the opposite edge on pin 0 must not set it
   task automatic t_irq;
      apb(1'b1, OFS_IRQCTL, 32'h80FF);
      apb(1'b1, OFS_IRQMASK, 32'hFF);
      apb(1'b1, OFS_FLAGS, 32'hFF);
      extLevel <= 8'h7F;
      repeat (5) @(posedge core_clk);
      chk({irq, pinIrqRequest}, 9'h1FF);
      apb(1'b1, OFS_SUMMARY, 32'hFFFF);
      apb(1'b1, OFS_FLAGS, RST_WORD);
      apb(1'b0, OFS_SUMMARY, 32'h1);
      apb(1'b0, OFS_FLAGS, 32'hFF);
      apb(1'b1, OFS_IRQMASK, RST_WORD);
      chk({irq, pinIrqRequest}, 9'h0FF);
      apb(1'b1, OFS_IRQCTL, 32'h8000);
      apb(1'b1, OFS_FLAGS, 32'h1);
      extLevel <= 8'h80;
      repeat (5) @(posedge core_clk);
      apb(1'b0, OFS_FLAGS, 32'hFE);
      chk({irq, pinIrqRequest}, 9'h000);
      apb(1'b1, OFS_FLAGS, 32'hFE);
      apb(1'b0, OFS_SUMMARY, RST_WORD);
   endtask : t_irq
   // reset, then scenarios
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_route();
      t_irq();
      test_done();
   end
endmodule : port_group0_tb

// >>> port_group_pkg.sv
// package for the port group 0 block: register offsets, field layout, reset values
// assumes a 32-bit apb slave with one aligned word per register
package port_group_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_SUMMARY   = 8'h00;
   localparam logic [7:0] OFS_DATA      = 8'h04;
   localparam logic [7:0] OFS_IOEN      = 8'h08;
   localparam logic [7:0] OFS_PULL      = 8'h0C;
   localparam logic [7:0] OFS_FLAGS     = 8'h10;
   localparam logic [7:0] OFS_IRQCTL    = 8'h14;
   localparam logic [7:0] OFS_DEBOUNCE  = 8'h18;
   localparam logic [7:0] OFS_MODESEL   = 8'h1C;
   localparam logic [7:0] OFS_FUNCSEL   = 8'h20;
   localparam logic [7:0] OFS_IRQMASK   = 8'h24;

   // geometry
   localparam int PIN_COUNT   = 8;
   localparam int GROUP_COUNT = 13;
   localparam int HI_FIELD    = 8;   // position of upper byte fields

   // summary bits that exist (groups able to interrupt); group 0 only is modelled here
   localparam logic [12:0] GROUP_IRQ_CAPABLE = 13'h0001;
   localparam int          GROUP_SELF        = 0;

   // reset values
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_HALF  = 16'h0000;
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;

   // function codes of the 2-bit selector
   localparam logic [1:0] FN_DEDICATED = 2'h0;
   localparam logic [1:0] FN_UNIVERSAL = 2'h1;

   // per-pin pad control bundle
   typedef struct packed {
      logic [7:0] outValue;
      logic [7:0] outEnable;
      logic [7:0] inEnable;
      logic [7:0] pullEnable;
      logic [7:0] pullDirection;
   } pad_ctrl_t;

   // peripheral side bundle, one bit per pin
   typedef struct packed {
      logic [7:0] outValue;
      logic [7:0] outEnable;
   } periph_drive_t;

endpackage : port_group_pkg
